// >>> logic/serial_port_pkg.sv
// Shared constants and types of the serial register port.
package serial_port_pkg;

   // Address space and register file size.
   localparam int ADDR_W = 5;
   localparam int NUM_REGS = 19;
   localparam logic [4:0] CFG_ADDR = 5'h00;
   localparam logic [4:0] KEEP_ADDR = 5'h04;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Fields of the port configuration register.
   localparam int CFG_PIN_MODE_BIT = 7;
   localparam int CFG_ORDER_BIT = 6;
   localparam int CFG_SOFT_RST_BIT = 5;

   // Fields of the instruction byte.
   localparam int INSTR_RW_BIT = 7;
   localparam int BYTE_COUNT_HI = 6;
   localparam int BYTE_COUNT_LO = 5;
   localparam int START_ADDR_MSB = 4;
   localparam int START_ADDR_LSB = 0;

   // Serial bit counting.
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] LAST_BYTE = 2'h0;

   // Pin synchroniser order and idle levels: clock low, select high, data low.
   localparam int PIN_COUNT = 3;
   localparam logic [2:0] PIN_IDLE = 3'h2;

   typedef enum logic [1:0] {
      PH_INSTR,
      PH_DATA,
      PH_DONE
   } phase_t;

endpackage

// >>> logic/pin_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins and their synchronised levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   always_comb begin
      next_st.meta = pin_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= {RESET_VAL, RESET_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign level = st.stable;

endmodule
`default_nettype wire

// >>> logic/reg_bank.sv
// Configuration register file with soft reset and zero reads off the map.
`timescale 1ns/1ps
`default_nettype none
module reg_bank
   import serial_port_pkg::*;
#(
   parameter int DEPTH = NUM_REGS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Byte write port
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Byte read port
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data,
   // Port configuration register
   output logic [7:0] cfg
);

   localparam int PROBE_IDX = 1;

   typedef struct packed {
      logic [DEPTH-1:0][7:0] regs;
   } bank_state_t;

   bank_state_t st;
   bank_state_t next_st;

   function automatic logic mapped(input logic [4:0] a);
      return int'(a) < DEPTH;
   endfunction

   always_comb begin
      next_st = st;
      if (wr_en && mapped(wr_addr)) begin
         if (wr_addr == CFG_ADDR && wr_data[CFG_SOFT_RST_BIT]) begin
            for (int i = 0; i < DEPTH; i++) begin
               if (i != int'(CFG_ADDR) && i != int'(KEEP_ADDR)) begin
                  next_st.regs[i] = REG_RESET;
               end
            end
         end
         next_st.regs[wr_addr] = wr_data;
         // The soft reset bit clears itself so a later write need not undo it.
         if (wr_addr == CFG_ADDR) begin
            next_st.regs[CFG_ADDR][CFG_SOFT_RST_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st.regs <= {DEPTH{REG_RESET}};
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = mapped(rd_addr) ? st.regs[rd_addr] : 8'h00;
   assign cfg = st.regs[CFG_ADDR];

   write_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_en && mapped(wr_addr) && wr_addr != CFG_ADDR) |=> st.regs[$past(wr_addr)] == $past(wr_data))
      else $error("Register did not take the written byte.");

   soft_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_en && wr_addr == CFG_ADDR && wr_data[CFG_SOFT_RST_BIT]) |=>
      st.regs[PROBE_IDX] == REG_RESET && st.regs[KEEP_ADDR] == $past(st.regs[KEEP_ADDR]))
      else $error("Soft reset cleared the wrong registers.");

   unmapped_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      !mapped(rd_addr) |-> rd_data == 8'h00)
      else $error("Unmapped address read non-zero.");

endmodule
`default_nettype wire

// >>> logic/serial_register_port.sv
// Serial slave port giving a host byte access to the configuration registers.
// Operation
// - First eight rising serial clock edges of each cycle carry the instruction byte.
// - Select going high then low restarts the port at the instruction phase.
// - Deselect mid-byte discards the partial bits and writes nothing.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6 and 5 give one to four data bytes.
// - Instruction bits 4 to 0 give the first address; later ones generated internally.
// - A written register updates as soon as its byte's last bit arrives.
// - Bits sampled on rising serial clock, read bits changed on falling edges.
// - Both data pins float while select is high.
// - Config bit 7 sets data pin mode; reset zero keeps it input only.
// - In single-pin mode the separate output floats; otherwise read data appears there.
// - Config bit 6 chooses bit order, default most significant first, instruction included.
// - Most significant first: address decreases by one after each byte.
// - Least significant first: address increases by one after each byte.
// - Generated address wraps within the five-bit space in either direction.
// - Order or pin mode written mid-cycle applies to the remaining bytes.
// - Soft reset bit defaults all registers except two, after its byte.
// - Select low: mode zero drives separate pin; mode one follows instruction direction.
`timescale 1ns/1ps
`default_nettype none
module serial_register_port
   import serial_port_pkg::*;
#(
   parameter int DEPTH = NUM_REGS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Serial link pins
   input wire logic serial_clk,
   input wire logic port_select_n,
   // Bidirectional data pin
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // Separate serial output pin
   output logic serial_out_pin,
   output logic serial_out_oe,
   // Port configuration as seen by the rest of the device
   output logic [7:0] port_cfg
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      phase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic is_read;
      logic [1:0] left;
      logic [4:0] addr;
      logic [7:0] tx;
      logic tx_load;
      logic out_bit;
      logic sclk_prev;
   } port_state_t;

   port_state_t st;
   port_state_t next_st;

   logic [PIN_COUNT-1:0] pins_s;
   logic sclk_s;
   logic csn_s;
   logic sdi_s;
   logic rise;
   logic fall;
   logic lsb_first;
   logic pin_mode;
   logic [7:0] assembled;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic [7:0] cfg;

   ////////////////////////////////////////////////////////////////////////////////
   // Address and bit-order helpers

   // Five-bit arithmetic wraps across addresses 31 and 0 in either
   // order, so a burst that runs off one end of the address space carries on at the other.
   function automatic logic [4:0] step_addr(input logic [4:0] a, input logic lsb);
      return lsb ? a + 5'h01 : a - 5'h01;
   endfunction

   // The bit that leaves first is the one that the host assembles first.
   function automatic logic out_pick(input logic [7:0] t, input logic lsb);
      return lsb ? t[0] : t[7];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and register file

   // All three pins come from the host's clock domain, so none is read raw.
   pin_sync #(
      .WIDTH(PIN_COUNT),
      .RESET_VAL(PIN_IDLE)
   ) u_pins (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in({serial_clk, port_select_n, sdio_in}),
      .level(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign csn_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // Reads and writes share one address, since a cycle never does both.
   reg_bank #(
      .DEPTH(DEPTH)
   ) u_bank (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(wr_en),
      .wr_addr(st.addr),
      .wr_data(wr_data),
      .rd_addr(st.addr),
      .rd_data(rd_data),
      .cfg(cfg)
   );

   // The live register value is used, so a mid-cycle write steers the next byte.
   assign lsb_first = cfg[CFG_ORDER_BIT];
   assign pin_mode = cfg[CFG_PIN_MODE_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection and bit assembly

   // The previous level resets to the idle low level, so no false rise follows reset.
   assign rise = sclk_s & ~st.sclk_prev;
   assign fall = ~sclk_s & st.sclk_prev;

   // The same shift direction serves the instruction byte and the data bytes.
   assign assembled = lsb_first ? {sdi_s, st.shift[7:1]} : {st.shift[6:0], sdi_s};

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      next_st = st;
      next_st.sclk_prev = sclk_s;
      next_st.tx_load = 1'b0;
      wr_en = 1'b0;
      wr_data = 8'h00;
      if (csn_s) begin
         // Partial bits are dropped here, so an unfinished byte never reaches a register.
         next_st.phase = PH_INSTR;
         next_st.bit_cnt = BIT_FIRST;
         next_st.shift = 8'h00;
         next_st.is_read = 1'b0;
         next_st.out_bit = 1'b0;
      end else begin
         // The read byte is fetched one clock after its address settles, well before
         // the falling edge that sends its first bit.
         if (st.tx_load) begin
            next_st.tx = rd_data;
         end
         if (rise && st.phase != PH_DONE) begin
            next_st.shift = assembled;
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == BIT_LAST) begin
               if (st.phase == PH_INSTR) begin
                  next_st.is_read = assembled[INSTR_RW_BIT];
                  next_st.left = assembled[BYTE_COUNT_HI:BYTE_COUNT_LO];
                  next_st.addr = assembled[START_ADDR_MSB:START_ADDR_LSB];
                  next_st.phase = PH_DATA;
                  next_st.tx_load = assembled[INSTR_RW_BIT];
               end else begin
                  wr_en = !st.is_read;
                  wr_data = assembled;
                  // Stepping uses the order in force for this byte; a new order follows it.
                  next_st.addr = step_addr(st.addr, lsb_first);
                  next_st.left = st.left - 2'h1;
                  next_st.tx_load = st.is_read && st.left != LAST_BYTE;
                  if (st.left == LAST_BYTE) begin
                     next_st.phase = PH_DONE;
                  end
               end
            end
         end
         if (fall && st.phase == PH_DATA && st.is_read) begin
            next_st.out_bit = out_pick(st.tx, lsb_first);
            next_st.tx = lsb_first ? {1'b0, st.tx[7:1]} : {st.tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '{phase: PH_INSTR, bit_cnt: BIT_FIRST, shift: 8'h00, is_read: 1'b0,
                 left: LAST_BYTE, addr: CFG_ADDR, tx: 8'h00, tx_load: 1'b0,
                 out_bit: 1'b0, sclk_prev: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers

   // Select is seen two clocks late; at the rated serial clock this is well
   // inside the host's select-to-clock setup.
   assign serial_out_pin = st.out_bit;
   assign sdio_out = st.out_bit;
   assign serial_out_oe = !csn_s && !pin_mode;
   // The shared pin turns round only after the instruction byte, so the host has
   // let go of it by the falling edge that presents the first read bit.
   assign sdio_oe = !csn_s && pin_mode && st.is_read && st.phase != PH_INSTR;
   assign port_cfg = cfg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   instr_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
      csn_s |=> st.phase == PH_INSTR && st.bit_cnt == BIT_FIRST)
      else $error("Deselect did not restart the instruction phase.");

   no_partial_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      csn_s |-> !wr_en)
      else $error("Write issued while deselected.");

   instr_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && rise && st.phase == PH_INSTR && st.bit_cnt == BIT_LAST) |=>
      st.phase == PH_DATA
      && st.is_read == $past(assembled[INSTR_RW_BIT])
      && st.left == $past(assembled[BYTE_COUNT_HI:BYTE_COUNT_LO])
      && st.addr == $past(assembled[START_ADDR_MSB:START_ADDR_LSB]))
      else $error("Instruction byte decoded wrongly.");

   write_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en |-> !st.is_read && st.phase == PH_DATA && st.bit_cnt == BIT_LAST)
      else $error("Write outside a write data byte.");

   byte_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && rise && st.phase == PH_DATA && st.bit_cnt == BIT_LAST && st.left == LAST_BYTE)
      |=> st.phase == PH_DONE ##1 (csn_s || st.phase == PH_DONE))
      else $error("Data phase did not end after the counted bytes.");

   addr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && rise && st.phase == PH_DATA && st.bit_cnt == BIT_LAST) |=>
      st.addr == ($past(lsb_first) ? $past(st.addr) + 5'h1 : $past(st.addr) - 5'h1))
      else $error("Address did not step in the bit-order direction.");

   out_on_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!$past(fall) && !$past(csn_s)) |-> $stable(st.out_bit))
      else $error("Read bit changed away from a falling edge.");

   tri_deselect_a: assert property (@(posedge clk) disable iff (sys_rst)
      csn_s |-> !sdio_oe && !serial_out_oe)
      else $error("Data pin driven while deselected.");

   sep_out_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      !csn_s |-> serial_out_oe == !pin_mode)
      else $error("Separate output enable disagrees with pin mode.");

   sdio_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
      sdio_oe |-> pin_mode && st.is_read && st.phase != PH_INSTR)
      else $error("Shared data pin driven outside a read.");

   // The checks below follow each byte through the sequencer one clock at a time.

   bit_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && rise && st.phase != PH_DONE) |=> st.bit_cnt == $past(st.bit_cnt) + 3'h1)
      else $error("Bit counter did not advance on a serial clock rise.");

   partial_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
      csn_s |=> st.shift == 8'h00 && st.bit_cnt == BIT_FIRST && !st.is_read)
      else $error("Partial bits survived a deselect.");

   read_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && st.tx_load) |=> st.tx == $past(rd_data))
      else $error("Read byte not loaded from the addressed register.");

   left_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && rise && st.phase == PH_DATA && st.bit_cnt == BIT_LAST) |=>
      st.left == $past(st.left) - 2'h1)
      else $error("Byte count did not step after a data byte.");

   done_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && st.phase == PH_DONE) |=> st.phase == PH_DONE && !wr_en)
      else $error("Port left the finished state before deselect.");

   addr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !rise |=> st.addr == $past(st.addr))
      else $error("Address moved without a serial clock rise.");

   out_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csn_s && fall && st.phase == PH_DATA && st.is_read) |=>
      st.out_bit == ($past(lsb_first) ? $past(st.tx[0]) : $past(st.tx[7])))
      else $error("Read bit taken from the wrong end of the byte.");

   cfg_live_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_en && st.addr == CFG_ADDR) |=>
      lsb_first == $past(wr_data[CFG_ORDER_BIT]) && pin_mode == $past(wr_data[CFG_PIN_MODE_BIT]))
      else $error("Configuration write did not apply to the next byte.");

endmodule
`default_nettype wire

// >>> verif/serial_host.sv
// Serial master model that drives the link pins of the register port.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   // Link clock and select
   output var logic serial_clk,
   output var logic port_select_n,
   // Data pins
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_out_pin,
   input wire logic serial_out_oe
);
   logic host_oe = 1'b1;
   logic host_bit = 1'b0;
   logic so_wire;

   // A released line shows the inverse of its last level, so a missed drive is never read as valid.
   assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~host_bit);
   assign so_wire = serial_out_oe ? serial_out_pin : ~serial_out_pin;

   initial begin
      serial_clk = 1'b0;
      port_select_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One framed cycle; the link clock stands still outside the frame.
   task automatic frame(input int nbits, input logic [39:0] tx, input logic bidir, input int rel,
                        output logic [39:0] rx, output logic saw_io, output logic saw_so);
      rx = '0;
      saw_io = 1'b0;
      saw_so = 1'b0;
      port_select_n = 1'b0;
      #32;
      for (int i = 0; i < nbits; i++) begin
         host_oe = (i < rel);
         host_bit = tx[39-i];
         #32 serial_clk = 1'b1;
         rx[39-i] = bidir ? sdio_in : so_wire;
         if (i >= 8) begin
            saw_io |= sdio_oe;
            saw_so |= serial_out_oe;
         end
         #32 serial_clk = 1'b0;
      end
      #32 port_select_n = 1'b1;
      host_oe = 1'b1;
      #40;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the serial register port.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import serial_port_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic serial_clk, port_select_n, sdio_in, sdio_out, sdio_oe, serial_out_pin, serial_out_oe;
   logic [7:0] port_cfg;
   logic [7:0] mem [0:31];
   logic lsb = 1'b0;
   logic bidir = 1'b0;
   int n_mismatch = 0;
   int checked = 0;

   serial_register_port i_dut (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
      .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .port_cfg(port_cfg));
   serial_host i_host (.serial_clk(serial_clk), .port_select_n(port_select_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
      .serial_out_oe(serial_out_oe));

   initial begin
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic finish_test();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [7:0] ord(input logic [7:0] b, input logic l);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) r[i] = b[7-i];
      return l ? r : b;
   endfunction

   // One cycle: n bytes from address a; cut > 0 ends the frame after that many bits.
   task automatic access(input logic rd, input int n, input logic [4:0] a, input logic [31:0] wd,
                         input int cut);
      logic [39:0] tx, rx;
      logic s_io, s_so, l, rb;
      logic [4:0] ad;
      logic [7:0] v, e;
      int nb;
      l = lsb;
      rb = bidir;
      tx = '0;
      tx[39:32] = ord({rd, 2'(n - 1), a}, l);
      for (int k = 0; k < n; k++) tx[31-8*k -: 8] = ord(wd[8*k +: 8], l);
      nb = (cut > 0) ? cut : 8 + 8 * n;
      i_host.frame(nb, tx, rb, (rd && rb) ? 8 : 99, rx, s_io, s_so);
      ad = a;
      for (int k = 0; k < n; k++) begin
         v = wd[8*k +: 8];
         e = (ad < NUM_REGS) ? mem[ad] : 8'h00;
         if (rd)
            chk(ord(rx[31-8*k -: 8], l) === e, "read data");
         else if (nb >= 16 + 8 * k && ad < NUM_REGS) begin
            mem[ad] = (ad == CFG_ADDR) ? (v & 8'hdf) : v;
            if (ad == CFG_ADDR) begin
               lsb = v[CFG_ORDER_BIT];
               bidir = v[CFG_PIN_MODE_BIT];
               if (v[CFG_SOFT_RST_BIT])
                  for (int j = 1; j < 32; j++) if (j != 4) mem[j] = 8'h00;
            end
         end
         ad = l ? ad + 5'h01 : ad - 5'h01;
      end
      chk(sdio_oe === 1'b0 && serial_out_oe === 1'b0, "pins not floating");
      chk(port_cfg === mem[0], "port_cfg");
      if (rd && cut == 0)
         chk(s_io === rb && s_so === !rb, "read pin choice");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int j = 0; j < 32; j++) mem[j] = 8'h00;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      chk(port_cfg === 8'h00 && sdio_oe === 1'b0, "reset state");
      access(1, 1, 5'h01, 0, 0);
      access(0, 4, 5'h08, 32'h44332211, 0);
      access(1, 4, 5'h08, 0, 0);
      access(0, 1, 5'h00, 32'h11, 0);
      access(0, 1, 5'h01, 32'h66, 0);
      access(1, 3, 5'h01, 0, 0);
      access(0, 1, 5'h05, 32'ha5, 12);
      access(0, 1, 5'h05, 32'h3c, 5);
      access(1, 2, 5'h06, 0, 0);
      $display("test msb_first done");
      access(0, 1, 5'h00, 32'h40, 0);
      access(0, 3, 5'h0a, 32'h778899, 0);
      access(1, 3, 5'h0a, 0, 0);
      access(0, 2, 5'h1f, 32'h40bb, 0);
      access(1, 2, 5'h0b, 0, 0);
      $display("test lsb_first done");
      access(0, 1, 5'h00, 32'h80, 0);
      access(1, 2, 5'h09, 0, 0);
      access(0, 1, 5'h00, 32'h00, 0);
      $display("test pin_mode done");
      access(0, 1, 5'h04, 32'h5a, 0);
      access(0, 1, 5'h01, 32'h33, 0);
      access(0, 1, 5'h00, 32'h20, 0);
      access(1, 2, 5'h01, 0, 0);
      access(1, 2, 5'h04, 0, 0);
      $display("test soft_reset done");
      finish_test();
   end

   initial begin
      #400000;
      chk(1'b0, "run timed out");
      finish_test();
   end
endmodule
`default_nettype wire
